/* File: src/bit_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low reset already synchronised.
`timescale 1ns/1ps

module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign push = in_valid && in_ready;
    // Register stage is refilled whenever it is empty or being taken
    assign pop = (count != '0) && (!out_valid || out_ready);

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end else if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* File: src/debug_link_cfg.svh */
// Constants of the single-wire debug link: cycle counts and widths.
// Assumes one clock domain, the debug serial clock at 25 MHz.
`ifndef DEBUG_LINK_CFG_SVH
`define DEBUG_LINK_CFG_SVH

// Serial clock period in ns
`define SERIAL_CLK_NS 40
// Low longer than this many cycles is a timing-reference request
`define SYNC_MIN_CYC 10'h080
// Wait after the line returns high before answering
`define SYNC_DELAY_CYC 10'h010
// Length of the low response pulse
`define SYNC_RESP_CYC 10'h080
// Gap between falling edges that ends an open transfer
`define TIMEOUT_CYC 10'h200
// Low shorter than this many cycles reads as a one
`define BIT_SAMPLE_CYC 10'h00A
// Counter width and its saturation value
`define CNT_W 10
`define CNT_MAX 10'h3FF
// Depth of the instruction tag queue
`define TAGQ_DEPTH 3
// Received bit buffer
`define FIFO_WIDTH 1
`define FIFO_DEPTH 8

`endif

/* File: src/debug_link_pkg.sv */
// Types shared by the debug link block.
// Assumes debug_link_cfg.svh is on the include path.
`include "debug_link_cfg.svh"

package debug_link_pkg;

    typedef enum logic [2:0] {
        LINK_IDLE,
        LINK_LOW,
        SYNC_WAIT_HIGH,
        SYNC_DELAY,
        SYNC_DRIVE,
        SYNC_SPEEDUP,
        LINK_TAGGING
    } link_state_t;

    typedef struct packed {
        link_state_t state;
        logic [`CNT_W-1:0] cnt;
        logic line_prev;
        logic line_out;
        logic line_oe;
        logic pend_valid;
        logic pend_bit;
        logic soft_reset;
        logic handshake_cancel;
        logic ack_enabled;
        logic ack_seen;
        logic external_bus_clock_prev;
        logic [1:0] tag_hold;
        logic [`TAGQ_DEPTH-1:0][1:0] tagq;
        logic step_pending;
        logic run_one_req;
        logic stack_irq_req;
        logic enter_debug;
    } link_regs_t;

endpackage

/* File: src/single_wire_debug_sync_timeout.sv */
// Debug line front end: timing-reference answer, serial time-out,
// single step and instruction tagging of the on-chip debug controller.
// Assumes all inputs synchronous to sys_clk; the command decoder sits
// outside and drains received bits from the buffer.
//
// Notes on behaviour
// - On a request, drop any partial command or bit, wait for line high.
// - After line high, wait 16 cycles, then drive low 128 cycles.
// - After the low answer, drive high exactly one cycle, then release.
// - After the answer, next falling edge starts a command or a request.
// - A request during a pending handshake cancels that handshake.
// - Single step leaves debug firmware, runs one instruction, returns.
// - With an interrupt pending, single step only stacks, runs nothing.
// - Tags travel in the queue; tagged head enters debug, not executed.
// - Tagging ends when debug mode starts; commands ignored while tagging.
// - Tag-and-run turns strobe pin and debug line into tag inputs.
// - Tag inputs sampled on bus clock fall; a zero tags that byte.
// - High tagging always works; low tagging only with strobe enabled.
// - Low over 128 cycles is a request; wait for rise without limit.
// - Short low is a bit; in an open transfer, no new fall in 512 cycles soft-resets.
// - Without handshake, read data unretrieved 512 cycles is discarded.
// - With handshake, read time-out waits for the handshake pulse.
// - Open transfer with gap over 512 cycles soft-resets.
// - Restart from clock-stopping wait soft-resets and disables handshake.
// - Inactive in stop; restart from stop soft-resets, disables handshake.
// - Handshake starts disabled after reset.
`timescale 1ns/1ps
`include "debug_link_cfg.svh"

module single_wire_debug_sync_timeout
    import debug_link_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Debug line pin
    input wire logic debug_line_in,
    output logic debug_line_out,
    output logic debug_line_oe,
    // Shared tag pins and bus clock
    input wire logic low_byte_strobe_in,
    input wire logic low_strobe_enable,
    input wire logic external_bus_clock,
    // Received bits towards the command decoder
    output logic bit_valid,
    output logic bit_value,
    input wire logic bit_ready,
    // Command decoder status
    input wire logic xfer_open,
    input wire logic read_wait,
    input wire logic ack_issued,
    input wire logic ack_enable_cmd,
    input wire logic ack_disable_cmd,
    // Link status
    output logic soft_reset,
    output logic handshake_cancel,
    output logic ack_enabled,
    output logic tagging_active,
    // Processor control
    input wire logic debug_active,
    input wire logic single_step_command,
    input wire logic tag_and_run_command,
    input wire logic irq_pending,
    input wire logic insn_boundary,
    input wire logic queue_load,
    input wire logic queue_head_exec,
    output logic run_one_req,
    output logic stack_irq_req,
    output logic enter_debug,
    // Low-power exits
    input wire logic wait_clock_restart,
    input wire logic stop_mode,
    input wire logic stop_clock_restart
);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rst_meta_n;
    logic rst_sync_n;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // Received bit buffer
    // ------------------------------------------------------------
    link_regs_t s;
    link_regs_t next_s;
    logic fifo_in_ready;

    bit_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH)
    ) u_bit_fifo (
        .clk(sys_clk),
        .rst_n(rst_sync_n),
        .flush(s.soft_reset),
        .in_valid(s.pend_valid),
        .in_data(s.pend_bit),
        .in_ready(fifo_in_ready),
        .out_valid(bit_valid),
        .out_data(bit_value),
        .out_ready(bit_ready)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic line_fall;
    logic external_bus_clock_fall;
    logic suspend;
    logic timeout;

    always_comb begin
        line_fall = s.line_prev && !debug_line_in;
        external_bus_clock_fall = s.external_bus_clock_prev && !external_bus_clock;
        // Read time-out held off until the handshake pulse has gone out
        suspend = s.ack_enabled && read_wait && !s.ack_seen;
        timeout = xfer_open && !suspend
                  && (s.cnt > `TIMEOUT_CYC);

        next_s = s;
        next_s.line_prev = debug_line_in;
        next_s.external_bus_clock_prev = external_bus_clock;
        next_s.soft_reset = 1'b0;
        next_s.handshake_cancel = 1'b0;
        next_s.run_one_req = 1'b0;
        next_s.stack_irq_req = 1'b0;
        next_s.enter_debug = 1'b0;
        if (s.cnt != `CNT_MAX) begin
            next_s.cnt = s.cnt + 1'b1;
        end
        if (s.pend_valid && fifo_in_ready) begin
            next_s.pend_valid = 1'b0;
        end

        // Handshake enable and its time-out bookkeeping
        if (ack_enable_cmd) begin
            next_s.ack_enabled = 1'b1;
        end else if (ack_disable_cmd) begin
            next_s.ack_enabled = 1'b0;
        end
        if (!read_wait) begin
            next_s.ack_seen = 1'b0;
        end
        if (ack_issued) begin
            next_s.ack_seen = 1'b1;
            next_s.cnt = '0;
        end

        case (s.state)
            LINK_IDLE: begin
                if (line_fall) begin
                    next_s.state = LINK_LOW;
                    next_s.cnt = '0;
                end else if (timeout) begin
                    next_s.soft_reset = 1'b1;
                    next_s.pend_valid = 1'b0;
                end
            end
            LINK_LOW: begin
                if (s.cnt > `SYNC_MIN_CYC) begin
                    // Request seen: drop partial work and any handshake
                    next_s.state = SYNC_WAIT_HIGH;
                    next_s.soft_reset = 1'b1;
                    next_s.handshake_cancel = 1'b1;
                    next_s.pend_valid = 1'b0;
                end else if (debug_line_in && !next_s.pend_valid) begin
                    next_s.state = LINK_IDLE;
                    next_s.pend_valid = 1'b1;
                    next_s.pend_bit = (s.cnt < `BIT_SAMPLE_CYC);
                end
            end
            SYNC_WAIT_HIGH: begin
                if (debug_line_in) begin
                    next_s.state = SYNC_DELAY;
                    next_s.cnt = '0;
                end
            end
            SYNC_DELAY: begin
                if (s.cnt == `SYNC_DELAY_CYC - 1'b1) begin
                    next_s.state = SYNC_DRIVE;
                    next_s.cnt = '0;
                    next_s.line_oe = 1'b1;
                    next_s.line_out = 1'b0;
                end
            end
            SYNC_DRIVE: begin
                if (s.cnt == `SYNC_RESP_CYC - 1'b1) begin
                    next_s.state = SYNC_SPEEDUP;
                    next_s.line_out = 1'b1;
                end
            end
            SYNC_SPEEDUP: begin
                next_s.state = LINK_IDLE;
                next_s.line_oe = 1'b0;
                next_s.line_prev = 1'b1;
                next_s.cnt = '0;
            end
            LINK_TAGGING: begin
                // Debug line is a tag input here, not a command line
                if (external_bus_clock_fall) begin
                    next_s.tag_hold[1] = s.tag_hold[1] | !debug_line_in;
                    next_s.tag_hold[0] = s.tag_hold[0]
                        | (!low_byte_strobe_in && low_strobe_enable);
                end
                if (debug_active) begin
                    next_s.state = LINK_IDLE;
                    next_s.tag_hold = '0;
                    next_s.line_prev = 1'b1;
                    next_s.cnt = '0;
                end
            end
            default: begin
                next_s.state = LINK_IDLE;
            end
        endcase

        // Tagging start takes both pins as tag inputs
        if (tag_and_run_command && s.state == LINK_IDLE) begin
            next_s.state = LINK_TAGGING;
            next_s.tag_hold = '0;
        end

        // Tags follow their instruction words through the queue
        if (queue_load) begin
            next_s.tagq = {s.tagq[`TAGQ_DEPTH-2:0], s.tag_hold};
            next_s.tag_hold = '0;
        end
        if (queue_head_exec && s.tagq[`TAGQ_DEPTH-1] != 2'h0) begin
            next_s.enter_debug = 1'b1;
        end

        // Single step from active debug mode
        if (single_step_command && debug_active) begin
            next_s.step_pending = 1'b1;
            if (irq_pending) begin
                next_s.stack_irq_req = 1'b1;
            end else begin
                next_s.run_one_req = 1'b1;
            end
        end else if (insn_boundary && s.step_pending) begin
            next_s.step_pending = 1'b0;
            next_s.enter_debug = 1'b1;
        end

        // Stop freezes the link; leaving wait or stop clears it
        if (stop_mode) begin
            next_s = s;
            next_s.line_oe = 1'b0;
            next_s.soft_reset = 1'b0;
            next_s.handshake_cancel = 1'b0;
            next_s.run_one_req = 1'b0;
            next_s.stack_irq_req = 1'b0;
            next_s.enter_debug = 1'b0;
        end else if (wait_clock_restart || stop_clock_restart) begin
            next_s.state = LINK_IDLE;
            next_s.soft_reset = 1'b1;
            next_s.ack_enabled = 1'b0;
            next_s.ack_seen = 1'b0;
            next_s.pend_valid = 1'b0;
            next_s.line_oe = 1'b0;
            next_s.line_prev = 1'b1;
            next_s.cnt = '0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s <= '0;
            s.state <= LINK_IDLE;
            s.line_prev <= 1'b1;
            s.external_bus_clock_prev <= 1'b1;
            s.ack_enabled <= 1'b0;
        end else begin
            s <= next_s;
        end
    end

    assign debug_line_out = s.line_out;
    assign debug_line_oe = s.line_oe;
    assign soft_reset = s.soft_reset;
    assign handshake_cancel = s.handshake_cancel;
    assign ack_enabled = s.ack_enabled;
    assign tagging_active = (s.state == LINK_TAGGING);
    assign run_one_req = s.run_one_req;
    assign stack_irq_req = s.stack_irq_req;
    assign enter_debug = s.enter_debug;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_n);

    logic [`CNT_W-1:0] low_run;
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            low_run <= '0;
        end else if (s.line_oe && !s.line_out) begin
            low_run <= low_run + 1'b1;
        end else begin
            low_run <= '0;
        end
    end

    answer_low_len_a: assert property (
        (s.line_oe && !s.line_out) ##1 s.line_out |-> low_run == `SYNC_RESP_CYC)
        else $error("sync answer low length wrong");
    speedup_one_a: assert property (
        (s.line_oe && s.line_out) |=> !s.line_oe && s.state == LINK_IDLE)
        else $error("speedup pulse not one cycle");
    answer_delay_a: assert property (
        $rose(s.line_oe) |-> $past(s.state == SYNC_DELAY, 1)
        && $past(s.state == SYNC_DELAY, 16) && !$past(s.line_oe, 16))
        else $error("answer not delayed 16 cycles");
    sync_drops_a: assert property (
        $rose(s.state == SYNC_WAIT_HIGH) |-> s.soft_reset && s.handshake_cancel
        && !s.pend_valid)
        else $error("request did not drop partial command");
    gap_timeout_a: assert property (
        (s.state == LINK_IDLE && timeout && !line_fall && !stop_mode
         && !tag_and_run_command) |=> s.soft_reset)
        else $error("missing time-out soft reset");
    wake_clear_a: assert property (
        (wait_clock_restart && !stop_mode) |=> s.soft_reset && !s.ack_enabled)
        else $error("wake did not clear link");
    tag_ends_a: assert property (
        (s.state == LINK_TAGGING && debug_active && !stop_mode)
        |=> !tagging_active)
        else $error("tagging stayed on in debug mode");
    tag_no_bits_a: assert property (
        tagging_active |-> !$rose(s.pend_valid))
        else $error("bit taken while tagging");
    step_run_a: assert property (
        (single_step_command && debug_active && !stop_mode)
        |=> ($past(irq_pending) ? (s.stack_irq_req && !s.run_one_req)
                                : (s.run_one_req && !s.stack_irq_req)))
        else $error("single step request wrong");

    sync_done_c: cover property (
        (s.line_oe && !s.line_out) ##1 (s.line_oe && s.line_out) ##1 !s.line_oe);
    timeout_c: cover property (s.state == LINK_IDLE && s.soft_reset);
    tag_enter_c: cover property (tagging_active ##[1:100] s.enter_debug);
endmodule

/* File: verif/debug_host_model.sv */
// Host pod model: drives the debug line and times the sync answer.
// Assumes the bench resolves the wire, with a pull-up when nobody drives.
`timescale 1ns/1ps

module debug_host_model (
    // Clock and resolved line
    input wire logic clk,
    input wire logic line,
    // Host drive
    output logic drv_oe,
    output logic drv_val
);
    initial begin
        drv_oe = 1'b0;
        drv_val = 1'b1;
    end

    // ------------------------------------------------------------
    // Line drive
    // ------------------------------------------------------------
    // Low for n cycles, optional one-cycle speedup, then release
    task automatic low(input int n, input bit sp);
        @(negedge clk);
        drv_oe = 1'b1;
        drv_val = 1'b0;
        repeat (n) @(negedge clk);
        drv_val = 1'b1;
        if (sp) @(negedge clk);
        drv_oe = 1'b0;
    endtask

    task automatic drive(input bit oe, input bit v);
        drv_oe = oe;
        drv_val = v;
    endtask

    // ------------------------------------------------------------
    // Answer timing
    // ------------------------------------------------------------
    // Cycles before the answer and length of its low part
    task automatic timing(output int dly, output int len);
        dly = 0;
        len = 0;
        while (line && dly < 1000) begin
            @(negedge clk);
            dly++;
        end
        while (!line && len < 1000) begin
            @(negedge clk);
            len++;
        end
    endtask
endmodule

/* File: verif/test_single_wire_debug_sync_timeout.sv */
// Testbench of the debug line front end.
// Assumes the host model on the line; decoder and core are the bench.
`timescale 1ns/1ps

module test_single_wire_debug_sync_timeout;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic strobe = 1'b1, strobe_en = 1'b0, bus_clk = 1'b0;
    logic bit_ready = 1'b1, xfer_open = 1'b0, read_wait = 1'b0;
    logic debug_active = 1'b0, irq_pending = 1'b0, stop_mode = 1'b0;
    // Pulses: ack en, ack dis, ack sent, step, tag run, boundary,
    // queue load, head exec, wait wake, stop wake
    logic [9:0] pls = 10'h000;
    logic line_out, line_oe, h_oe, h_val, bit_valid, bit_value;
    logic soft_reset, hs_cancel, ack_enabled, tagging_active;
    logic run_one_req, stack_irq_req, enter_debug, last_bit;
    wire debug_line = line_oe ? line_out : (h_oe ? h_val : 1'b1);
    int num_errors = 0, n_compared = 0;
    int n_sr = 0, n_hc = 0, n_bit = 0, n_run = 0, n_stk = 0, n_ent = 0;
    int s, nb, d, l;

    always #20 sys_clk = ~sys_clk;

    single_wire_debug_sync_timeout u_single_wire_debug_sync_timeout (
        .sys_clk(sys_clk), .rst_n(rst_n), .debug_line_in(debug_line),
        .debug_line_out(line_out), .debug_line_oe(line_oe),
        .low_byte_strobe_in(strobe), .low_strobe_enable(strobe_en),
        .external_bus_clock(bus_clk), .bit_valid(bit_valid),
        .bit_value(bit_value), .bit_ready(bit_ready),
        .xfer_open(xfer_open), .read_wait(read_wait),
        .ack_issued(pls[2]), .ack_enable_cmd(pls[0]),
        .ack_disable_cmd(pls[1]), .soft_reset(soft_reset),
        .handshake_cancel(hs_cancel), .ack_enabled(ack_enabled),
        .tagging_active(tagging_active), .debug_active(debug_active),
        .single_step_command(pls[3]), .tag_and_run_command(pls[4]),
        .irq_pending(irq_pending), .insn_boundary(pls[5]),
        .queue_load(pls[6]), .queue_head_exec(pls[7]),
        .run_one_req(run_one_req), .stack_irq_req(stack_irq_req),
        .enter_debug(enter_debug), .wait_clock_restart(pls[8]),
        .stop_mode(stop_mode), .stop_clock_restart(pls[9]));

    debug_host_model u_debug_host_model (
        .clk(sys_clk), .line(debug_line), .drv_oe(h_oe), .drv_val(h_val));

    // ------------------------------------------------------------
    // Output pulse counters
    // ------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (soft_reset === 1'b1) n_sr++;
        if (hs_cancel === 1'b1) n_hc++;
        if (run_one_req === 1'b1) n_run++;
        if (stack_irq_req === 1'b1) n_stk++;
        if (enter_debug === 1'b1) n_ent++;
        if (bit_valid === 1'b1 && bit_ready === 1'b1) begin
            n_bit++;
            last_bit = bit_value;
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic pulse(input int k);
        pls[k] = 1'b1;
        tick(1);
        pls[k] = 1'b0;
        tick(3);
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("errors %0d, compares %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One tagging run: tag pin levels, strobe enable, expected entries
    task automatic tag_round(input bit hi, lo, en, input int exp);
        int e0;
        int b0;
        e0 = n_ent;
        b0 = n_bit;
        debug_active = 1'b0;
        pulse(4);
        check(tagging_active, 1);
        u_debug_host_model.drive(!hi, 1'b0);
        strobe = lo;
        strobe_en = en;
        bus_clk = 1'b1;
        tick(2);
        bus_clk = 1'b0;
        tick(2);
        u_debug_host_model.drive(1'b0, 1'b1);
        strobe = 1'b1;
        repeat (3) pulse(6);
        pulse(7);
        check(n_ent - e0, exp);
        debug_active = 1'b1;
        tick(3);
        check(tagging_active, 0);
        check(n_bit, b0);
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        num_errors++;
        end_of_test;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        tick(10);
        rst_n = 1'b1;
        tick(4);
        check(ack_enabled, 0);
        check(line_oe, 0);
        u_debug_host_model.low(4, 0);
        tick(20);
        check(last_bit, 1);
        u_debug_host_model.low(20, 0);
        tick(20);
        check({last_bit, n_bit[7:0]}, 9'h002);
        // Queue eight bits in the bit buffer with the decoder stalled, then drain
        bit_ready = 1'b0;
        repeat (8) begin
            u_debug_host_model.low(4, 0);
            tick(12);
        end
        check({bit_valid, n_bit[7:0]}, 9'h102);
        bit_ready = 1'b1;
        tick(12);
        check({bit_valid, n_bit[7:0]}, 9'h00A);
        // Sync request held past the time-out span, then the answer
        s = n_sr;
        nb = n_hc;
        u_debug_host_model.low(600, 1);
        check(n_sr - s, 1);
        check(n_hc - nb, 1);
        u_debug_host_model.timing(d, l);
        check(d >= 14 && d <= 18, 1);
        check(l, 128);
        check({line_oe, line_out}, 2'h3);
        tick(1);
        check(line_oe, 0);
        nb = n_bit;
        u_debug_host_model.low(4, 0);
        tick(20);
        check(n_bit - nb, 1);
        // Time-out with a read pending, handshake off
        xfer_open = 1'b1;
        read_wait = 1'b1;
        s = n_sr;
        u_debug_host_model.low(4, 0);
        tick(490);
        check(n_sr - s, 0);
        tick(40);
        check(n_sr > s, 1);
        xfer_open = 1'b0;
        pulse(0);
        check(ack_enabled, 1);
        // Handshake on: time-out waits for the handshake pulse
        xfer_open = 1'b1;
        s = n_sr;
        u_debug_host_model.low(4, 0);
        tick(700);
        check(n_sr - s, 0);
        pulse(2);
        tick(486);
        check(n_sr - s, 0);
        tick(40);
        check(n_sr > s, 1);
        xfer_open = 1'b0;
        read_wait = 1'b0;
        pulse(1);
        check(ack_enabled, 0);
        // Wake from wait and from stop
        pulse(0);
        s = n_sr;
        pulse(8);
        check(ack_enabled, 0);
        check(n_sr - s, 1);
        pulse(0);
        stop_mode = 1'b1;
        nb = n_bit;
        u_debug_host_model.low(4, 0);
        tick(20);
        stop_mode = 1'b0;
        pulse(9);
        check(ack_enabled, 0);
        check(n_sr - s, 2);
        check(n_bit, nb);
        // Single step, plain and with an interrupt pending
        debug_active = 1'b1;
        s = n_ent;
        pulse(3);
        check({n_run[7:0], n_stk[7:0]}, 16'h0100);
        pulse(5);
        check(n_ent - s, 1);
        irq_pending = 1'b1;
        pulse(3);
        check({n_run[7:0], n_stk[7:0]}, 16'h0101);
        irq_pending = 1'b0;
        // Tagging: none, low refused, low, high
        tag_round(1, 1, 1, 0);
        tag_round(1, 0, 0, 0);
        tag_round(1, 0, 1, 1);
        tag_round(0, 1, 0, 1);
        end_of_test;
    end
endmodule
